// [hw/ddit_cond.v]
// One input channel: sampling filter, polarity inversion, switch-on/off delay
`timescale 1ns/10ps
module ddit_cond (
    input  wire        clk,
    input  wire        srst,
    input  wire        ms_tick,
    input  wire        raw_level,
    input  wire        polarity,
    input  wire [15:0] filter_ms,
    input  wire [15:0] on_delay_ms,
    input  wire [15:0] off_delay_ms,
    output reg         level
);

    reg         filtered;
    reg  [15:0] filt_cnt;
    reg  [15:0] dly_cnt;
    wire        polar;
    wire [15:0] dly_limit;

    // ======================================================================
    // Sampling filter: new level must hold for the whole filter time
    always @(posedge clk) begin
        if (srst) begin
            filtered <= 1'b0;
            filt_cnt <= 16'h0000;
        end else if (raw_level == filtered) begin
            filt_cnt <= 16'h0000;
        end else if (filt_cnt >= filter_ms) begin
            filtered <= raw_level;
            filt_cnt <= 16'h0000;
        end else if (ms_tick) begin
            filt_cnt <= filt_cnt + 16'h0001;
        end
    end

    assign polar     = filtered ^ polarity;
    assign dly_limit = polar ? on_delay_ms : off_delay_ms;

    // ======================================================================
    // Switch-on/off delay after polarity
    always @(posedge clk) begin
        if (srst) begin
            level   <= 1'b0;
            dly_cnt <= 16'h0000;
        end else if (polar == level) begin
            dly_cnt <= 16'h0000;
        end else if (dly_cnt >= dly_limit) begin
            level   <= polar;
            dly_cnt <= 16'h0000;
        end else if (ms_tick) begin
            dly_cnt <= dly_cnt + 16'h0001;
        end
    end

endmodule // ddit_cond

// [hw/ddit_consts.vh]
// Offsets, fields, reset values and timing of the input terminal block
// How it works
// - A rising clear-energy function (code 40) zeroes the energy counter.
// - Hold-energy function (code 41) freezes the energy counter.
// - While function 42 is active the braking torque limit comes from the keypad.
// - While function 61 is active the PID output polarity is inverted.
// - Fast input is a pulse input when type is 0, a switch when 1.
// - Nine function selects, codes 0 to 95, defaults 1, 4, 7 then 0.
// - Inputs five to eight have no pin; only the virtual value drives them.
// - Nine polarity bits; 1 makes that input active when its contact opens.
// - One common filter time, 0 to 50000 ms, default 10 ms, for all inputs.
// - Virtual mask bit 0 is input one, bit 7 input eight, bit 8 fast input.
// - Two-bit run control scheme selects modes 0 to 3, default 0.
// - Mode 0 takes run and direction from the forward and reverse commands.
// - Mode 0 stops with both commands off, runs reverse with only reverse on.
// - Mode 1 uses forward as run enable, reverse input gives the direction.
// - Mode 2 starts on forward rising edge with enable closed; enable open stops.
// - Mode 3 starts on forward or reverse rising edge in that direction.
`ifndef DDIT_CONSTS_VH
`define DDIT_CONSTS_VH

// ==========================================================================
// Register offsets
`define DDIT_REG_FAST_TYPE   8'h00
`define DDIT_REG_FUNC_BASE   8'h01
`define DDIT_REG_POLARITY    8'h0A
`define DDIT_REG_FILTER      8'h0B
`define DDIT_REG_VIRT_MASK   8'h0C
`define DDIT_REG_SCHEME      8'h0D
`define DDIT_REG_DELAY_BASE  8'h0E
`define DDIT_REG_VIRT_VALUE  8'h20
`define DDIT_REG_LEVELS      8'h21
`define DDIT_REG_COMMANDS    8'h22
`define DDIT_REG_ENERGY      8'h23

// ==========================================================================
// Sizes and limits
`define DDIT_NUM_INPUTS      9
`define DDIT_FUNC_MAX        7'h5F
`define DDIT_TIME_MAX_MS     16'hC350

// ==========================================================================
// Reset values
`define DDIT_RST_FAST_TYPE   1'h0
`define DDIT_RST_FUNC1       7'h01
`define DDIT_RST_FUNC2       7'h04
`define DDIT_RST_FUNC3       7'h07
`define DDIT_RST_FUNC_OTHER  7'h00
`define DDIT_RST_POLARITY    9'h000
`define DDIT_RST_FILTER_MS   16'h000A
`define DDIT_RST_VIRT_MASK   9'h000
`define DDIT_RST_SCHEME      2'h0
`define DDIT_RST_DELAY_MS    16'h0000

// ==========================================================================
// Function codes
`define DDIT_FN_FORWARD      7'h01
`define DDIT_FN_REVERSE      7'h02
`define DDIT_FN_THREE_WIRE   7'h03
`define DDIT_FN_ENERGY_CLEAR 7'h28
`define DDIT_FN_ENERGY_HOLD  7'h29
`define DDIT_FN_TORQUE_KEYPAD 7'h2A
`define DDIT_FN_PID_INVERT   7'h3D

// ==========================================================================
// Run control schemes
`define DDIT_SCHEME_TWO_WIRE1   2'h0
`define DDIT_SCHEME_TWO_WIRE2   2'h1
`define DDIT_SCHEME_THREE_WIRE1 2'h2
`define DDIT_SCHEME_THREE_WIRE2 2'h3

// ==========================================================================
// Timing
`define DDIT_CLK_PERIOD_NS   50
`define DDIT_TICK_TIME_NS    1000000

`endif

// [hw/ddit_top.v]
// Top of the drive digital input terminal block: registers, sources, decode, run control
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`include "ddit_consts.vh"
module ddit_top #(
    parameter integer TICK_CYCLES = `DDIT_TICK_TIME_NS / `DDIT_CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        srst,
    input  wire [7:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rd_data,
    input  wire [3:0]  switch_pins,
    input  wire        fast_dual_use_input,
    input  wire        energy_increment,
    output reg         fast_pulse_level,
    output reg         energy_clear,
    output reg         energy_hold,
    output reg  [31:0] energy_count,
    output reg         torque_limit_keypad,
    output reg         pid_invert,
    output reg         run_command,
    output reg         reverse_command
);

    localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

    // ======================================================================
    // Configuration registers
    reg         fast_input_type;
    reg  [6:0]  func_sel   [0:8];
    reg  [8:0]  input_polarity_mask;
    reg  [15:0] input_filter_time;
    reg  [8:0]  virtual_input_mask;
    reg  [1:0]  run_control_scheme;
    reg  [15:0] on_delay   [0:8];
    reg  [15:0] off_delay  [0:8];
    reg  [8:0]  virtual_input_value;

    reg  [4:0]  pin_meta;
    reg  [4:0]  pin_sync;
    reg  [15:0] tick_cnt;
    reg         ms_tick;
    wire [8:0]  raw_src;
    wire [8:0]  cond_level;
    wire [8:0]  func_level;
    wire [62:0] func_flat;
    reg         prev_clear;
    reg         prev_fwd;
    reg         prev_rev;

    wire [7:0]  func_off  = addr - `DDIT_REG_FUNC_BASE;
    wire [7:0]  dly_off   = addr - `DDIT_REG_DELAY_BASE;
    wire        func_hit  = (addr >= `DDIT_REG_FUNC_BASE) && (func_off < 8'h09);
    wire        dly_hit   = (addr >= `DDIT_REG_DELAY_BASE) && (dly_off < 8'h12);
    wire [3:0]  func_idx  = func_off[3:0];
    wire [3:0]  dly_idx   = dly_off[4:1];
    wire        dly_is_off = dly_off[0];

    integer     i;

    // ======================================================================
    // Helpers
    function ddit_fn_active;
        input [62:0] codes;
        input [8:0]  lvl;
        input [6:0]  code;
        integer      k;
        begin
            ddit_fn_active = 1'b0;
            for (k = 0; k < 9; k = k + 1) begin
                if (codes[7*k +: 7] == code && lvl[k])
                    ddit_fn_active = 1'b1;
            end
        end
    endfunction

    function ddit_time_ok;
        input [31:0] value;
        begin
            ddit_time_ok = (value[31:16] == 16'h0000) && (value[15:0] <= `DDIT_TIME_MAX_MS);
        end
    endfunction

    // ======================================================================
    // Register writes; out-of-range filter, delay and function values are ignored, keeping the old one
    always @(posedge clk) begin
        if (srst) begin
            fast_input_type     <= `DDIT_RST_FAST_TYPE;
            input_polarity_mask <= `DDIT_RST_POLARITY;
            input_filter_time   <= `DDIT_RST_FILTER_MS;
            virtual_input_mask  <= `DDIT_RST_VIRT_MASK;
            run_control_scheme  <= `DDIT_RST_SCHEME;
            virtual_input_value <= 9'h000;
            for (i = 0; i < 9; i = i + 1) begin
                func_sel[i]  <= `DDIT_RST_FUNC_OTHER;
                on_delay[i]  <= `DDIT_RST_DELAY_MS;
                off_delay[i] <= `DDIT_RST_DELAY_MS;
            end
            func_sel[0] <= `DDIT_RST_FUNC1;
            func_sel[1] <= `DDIT_RST_FUNC2;
            func_sel[2] <= `DDIT_RST_FUNC3;
        end else if (wr_en) begin
            if (addr == `DDIT_REG_FAST_TYPE)
                fast_input_type <= wr_data[0];
            if (addr == `DDIT_REG_POLARITY)
                input_polarity_mask <= wr_data[8:0];
            if (addr == `DDIT_REG_FILTER && ddit_time_ok(wr_data))
                input_filter_time <= wr_data[15:0];
            if (addr == `DDIT_REG_VIRT_MASK)
                virtual_input_mask <= wr_data[8:0];
            if (addr == `DDIT_REG_SCHEME)
                run_control_scheme <= wr_data[1:0];
            if (addr == `DDIT_REG_VIRT_VALUE)
                virtual_input_value <= wr_data[8:0];
            if (func_hit && wr_data[31:7] == 25'h0000000 && wr_data[6:0] <= `DDIT_FUNC_MAX)
                func_sel[func_idx] <= wr_data[6:0];
            if (dly_hit && ddit_time_ok(wr_data)) begin
                if (dly_is_off)
                    off_delay[dly_idx] <= wr_data[15:0];
                else
                    on_delay[dly_idx] <= wr_data[15:0];
            end
        end
    end

    // ======================================================================
    // Register reads, data in the cycle after the strobe
    always @(posedge clk) begin
        if (srst) begin
            rd_data <= 32'h00000000;
        end else if (rd_en) begin
            rd_data <= 32'h00000000;
            if (addr == `DDIT_REG_FAST_TYPE)
                rd_data <= {31'h00000000, fast_input_type};
            if (addr == `DDIT_REG_POLARITY)
                rd_data <= {23'h000000, input_polarity_mask};
            if (addr == `DDIT_REG_FILTER)
                rd_data <= {16'h0000, input_filter_time};
            if (addr == `DDIT_REG_VIRT_MASK)
                rd_data <= {23'h000000, virtual_input_mask};
            if (addr == `DDIT_REG_SCHEME)
                rd_data <= {30'h00000000, run_control_scheme};
            if (addr == `DDIT_REG_VIRT_VALUE)
                rd_data <= {23'h000000, virtual_input_value};
            if (addr == `DDIT_REG_LEVELS)
                rd_data <= {23'h000000, func_level};
            if (addr == `DDIT_REG_COMMANDS)
                rd_data <= {25'h0000000, fast_pulse_level, reverse_command, run_command,
                            pid_invert, torque_limit_keypad, energy_hold, energy_clear};
            if (addr == `DDIT_REG_ENERGY)
                rd_data <= energy_count;
            if (func_hit)
                rd_data <= {25'h0000000, func_sel[func_idx]};
            if (dly_hit)
                rd_data <= {16'h0000, dly_is_off ? off_delay[dly_idx] : on_delay[dly_idx]};
        end
    end

    // ======================================================================
    // Pin synchronisers and millisecond tick
    always @(posedge clk) begin
        if (srst) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            pin_meta <= {fast_dual_use_input, switch_pins};
            pin_sync <= pin_meta;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            tick_cnt <= 16'h0000;
            ms_tick  <= 1'b0;
        end else if (tick_cnt >= TICK_LAST) begin
            tick_cnt <= 16'h0000;
            ms_tick  <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            ms_tick  <= 1'b0;
        end
    end

    // ======================================================================
    // Source selection: pin or software value
    // Inputs five to eight have no pin, so without the mask their raw source is low
    assign raw_src[3:0] = (virtual_input_mask[3:0] & virtual_input_value[3:0]) |
                          (~virtual_input_mask[3:0] & pin_sync[3:0]);
    assign raw_src[7:4] = virtual_input_mask[7:4] & virtual_input_value[7:4];
    assign raw_src[8]   = virtual_input_mask[8] ? virtual_input_value[8] : pin_sync[4];

    genvar g;
    generate
        for (g = 0; g < 9; g = g + 1) begin : gen_chan
            ddit_cond u_cond (
                .clk          (clk),
                .srst         (srst),
                .ms_tick      (ms_tick),
                .raw_level    (raw_src[g]),
                .polarity     (input_polarity_mask[g]),
                .filter_ms    (input_filter_time),
                .on_delay_ms  (on_delay[g]),
                .off_delay_ms (off_delay[g]),
                .level        (cond_level[g])
            );
            assign func_flat[7*g +: 7] = func_sel[g];
        end
    endgenerate

    // Fast input decodes as a switch only in switch mode or when virtual
    assign func_level[7:0] = cond_level[7:0];
    assign func_level[8]   = cond_level[8] & (fast_input_type | virtual_input_mask[8]);

    // ======================================================================
    // Function decode and energy counter
    wire fn_clear  = ddit_fn_active(func_flat, func_level, `DDIT_FN_ENERGY_CLEAR);
    wire fn_hold   = ddit_fn_active(func_flat, func_level, `DDIT_FN_ENERGY_HOLD);
    wire fn_torque = ddit_fn_active(func_flat, func_level, `DDIT_FN_TORQUE_KEYPAD);
    wire fn_pid    = ddit_fn_active(func_flat, func_level, `DDIT_FN_PID_INVERT);
    wire fn_fwd    = ddit_fn_active(func_flat, func_level, `DDIT_FN_FORWARD);
    wire fn_rev    = ddit_fn_active(func_flat, func_level, `DDIT_FN_REVERSE);
    wire fn_enable = ddit_fn_active(func_flat, func_level, `DDIT_FN_THREE_WIRE);
    wire fwd_rise  = fn_fwd & ~prev_fwd;
    wire rev_rise  = fn_rev & ~prev_rev;

    always @(posedge clk) begin
        if (srst) begin
            prev_clear          <= 1'b0;
            prev_fwd            <= 1'b0;
            prev_rev            <= 1'b0;
            energy_clear        <= 1'b0;
            energy_hold         <= 1'b0;
            torque_limit_keypad <= 1'b0;
            pid_invert          <= 1'b0;
            fast_pulse_level    <= 1'b0;
            energy_count        <= 32'h00000000;
        end else begin
            prev_clear          <= fn_clear;
            prev_fwd            <= fn_fwd;
            prev_rev            <= fn_rev;
            energy_clear        <= fn_clear & ~prev_clear;
            energy_hold         <= fn_hold;
            torque_limit_keypad <= fn_torque;
            pid_invert          <= fn_pid;
            // Pulse path sees the synchronised pin only in pulse mode
            fast_pulse_level    <= ~fast_input_type & pin_sync[4];
            // Clear beats hold and increment so a cleared count starts at zero
            if (fn_clear & ~prev_clear)
                energy_count <= 32'h00000000;
            else if (energy_increment & ~fn_hold)
                energy_count <= energy_count + 32'h00000001;
        end
    end

    // ======================================================================
    // Run control schemes
    always @(posedge clk) begin
        if (srst) begin
            run_command     <= 1'b0;
            reverse_command <= 1'b0;
        end else begin
            case (run_control_scheme)
                `DDIT_SCHEME_TWO_WIRE1: begin
                    // Both commands on is treated as stop
                    run_command     <= fn_fwd ^ fn_rev;
                    reverse_command <= fn_rev & ~fn_fwd;
                end
                `DDIT_SCHEME_TWO_WIRE2: begin
                    run_command     <= fn_fwd;
                    reverse_command <= fn_rev;
                end
                `DDIT_SCHEME_THREE_WIRE1: begin
                    if (!fn_enable)
                        run_command <= 1'b0;
                    else if (fwd_rise)
                        run_command <= 1'b1;
                    reverse_command <= fn_rev;
                end
                `DDIT_SCHEME_THREE_WIRE2: begin
                    if (!fn_enable) begin
                        run_command <= 1'b0;
                    end else if (fwd_rise) begin
                        run_command     <= 1'b1;
                        reverse_command <= 1'b0;
                    end else if (rev_rise) begin
                        run_command     <= 1'b1;
                        reverse_command <= 1'b1;
                    end
                end
                default: begin
                    run_command     <= 1'b0;
                    reverse_command <= 1'b0;
                end
            endcase
        end
    end

endmodule // ddit_top

// [verif/ddit_chk.sv]
// Assertions on the terminal block outputs
`timescale 1ns/10ps
module ddit_chk (
    input wire        clk,
    input wire        srst,
    input wire [7:0]  addr,
    input wire        rd_en,
    input wire [31:0] rd_data,
    input wire        energy_clear,
    input wire        energy_hold,
    input wire [31:0] energy_count,
    input wire        torque_limit_keypad,
    input wire        pid_invert,
    input wire        run_command,
    input wire        reverse_command,
    input wire        fast_pulse_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ==========
    // Energy counter
    a_clear_pulse: assert property (energy_clear |=> !energy_clear)
        else $error("clear too long");
    a_clear_zeroes: assert property (energy_clear |-> ##[0:1] (energy_count == 32'h0))
        else $error("clear kept count");
    a_hold_freeze: assert property (energy_hold && $past(energy_hold) && !energy_clear && !$past(energy_clear)
        |-> $stable(energy_count))
        else $error("count moved in hold");
    a_count_step: assert property (1'b1 |=> (energy_count == $past(energy_count)
        || energy_count == $past(energy_count) + 32'h1 || energy_count == 32'h0))
        else $error("count jumped");

    // ==========
    // Register reads and quiet outputs after reset
    a_cmd_readback: assert property (rd_en && addr == 8'h22 |=> rd_data == {25'h0, $past({fast_pulse_level,
        reverse_command, run_command, pid_invert, torque_limit_keypad, energy_hold, energy_clear})})
        else $error("command readback");
    a_energy_readback: assert property (rd_en && addr == 8'h23 |=> rd_data == $past(energy_count))
        else $error("energy readback");
    a_unmapped_read: assert property (rd_en && addr > 8'h23 |=> rd_data == 32'h0)
        else $error("unmapped read");
    a_rd_hold: assert property (!rd_en |=> $stable(rd_data))
        else $error("rd_data moved");
    a_reset_quiet: assert property ($fell(srst) |-> !run_command && !energy_hold && energy_count == 32'h0)
        else $error("active after reset");

    c_reverse_run: cover property (run_command && reverse_command);
    c_clear: cover property (energy_clear);
    c_torque_pid: cover property (pid_invert && torque_limit_keypad);
    c_fast: cover property ($rose(fast_pulse_level));
endmodule // ddit_chk

// [verif/ddit_contact_model.sv]
// External contacts on the physical inputs, with optional bounce
`timescale 1ns/10ps
module ddit_contact_model (
    input  wire       clk,
    input  wire [4:0] target,
    input  wire [3:0] bounce,
    output reg  [4:0] contacts
);
    reg [4:0] last;
    reg [4:0] chg;
    reg [3:0] cnt;

    initial begin
        contacts = 5'h00;
        last     = 5'h00;
        chg      = 5'h00;
        cnt      = 4'h0;
    end

    // Changed contacts chatter, then settle
    always @(posedge clk) begin
        if (target != last) begin
            last     <= target;
            chg      <= target ^ last;
            cnt      <= bounce;
            contacts <= (bounce != 4'h0) ? last : target;
        end else if (cnt != 4'h0) begin
            cnt      <= cnt - 4'h1;
            contacts <= target ^ (chg & {5{cnt[0]}});
        end else begin
            contacts <= target;
        end
    end
endmodule // ddit_contact_model

// [verif/ddit_tb_top.sv]
// Self-checking bench of the input terminal block
`timescale 1ns/10ps
module ddit_tb_top;
    reg         clk;
    reg         srst = 1'b1;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wr_data = 32'h0;
    reg         wr_en = 1'b0, rd_en = 1'b0, energy_increment = 1'b0;
    reg  [4:0]  target = 5'h00;
    reg  [3:0]  bounce = 4'h0;
    wire [4:0]  contacts;
    wire [31:0] rd_data, energy_count;
    wire        fast_pulse_level, energy_clear, energy_hold, torque_limit_keypad;
    wire        pid_invert, run_command, reverse_command;
    integer     seed = 75, miscompares = 0, tests_run = 0, i, m, k, n, m_count = 0;
    reg  [31:0] v, p;
    reg  [6:0]  fm [0:8];
    reg         m_run, m_dir, p_f, p_r;

    // Short tick keeps millisecond times to a few cycles
    ddit_top #(.TICK_CYCLES(4)) i_ddit_top (
        .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .switch_pins(contacts[3:0]), .fast_dual_use_input(contacts[4]),
        .energy_increment(energy_increment), .fast_pulse_level(fast_pulse_level),
        .energy_clear(energy_clear), .energy_hold(energy_hold), .energy_count(energy_count),
        .torque_limit_keypad(torque_limit_keypad), .pid_invert(pid_invert),
        .run_command(run_command), .reverse_command(reverse_command));
    ddit_contact_model i_ddit_contact_model (.clk(clk), .target(target), .bounce(bounce), .contacts(contacts));

    // ==========
    // Helpers
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task cyc(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] dat);
        begin
            @(posedge clk);
            addr    <= a;
            wr_data <= dat;
            wr_en   <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    task rc(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk);
            addr  <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1;
            chk(rd_data, exp);
        end
    endtask
    task setp(input [4:0] t);
        begin
            @(posedge clk);
            target <= t;
        end
    endtask
    task inc(input integer c);
        begin
            repeat (c) begin
                @(posedge clk);
                energy_increment <= 1'b1;
            end
            @(posedge clk);
            energy_increment <= 1'b0;
        end
    endtask
    function [31:0] rst_val(input [7:0] a);
        case (a)
            8'h01: rst_val = 32'h1;
            8'h02: rst_val = 32'h4;
            8'h03: rst_val = 32'h7;
            8'h0B: rst_val = 32'hA;
            default: rst_val = 32'h0;
        endcase
    endfunction
    task run_model(input integer md, input f, input r, input e);
        begin
            if (md == 0) begin
                m_run = f ^ r;
                m_dir = r;
            end else if (md == 1) begin
                m_run = f;
                m_dir = r;
            end else if (!e) begin
                m_run = 1'b0;
            end else if (f && !p_f) begin
                m_run = 1'b1;
                m_dir = (md == 2) ? r : 1'b0;
            end else if (md == 3 && r && !p_r) begin
                m_run = 1'b1;
                m_dir = 1'b1;
            end else if (md == 2) begin
                m_dir = r;
            end
            p_f = f;
            p_r = r;
        end
    endtask
    task stop_test;
        begin
            $display("runs=%0d errors=%0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // ==========
    // Clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 30000);
        miscompares = miscompares + 1;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 38; i = i + 1)
            rc(i[7:0], rst_val(i[7:0]));
        $display("done: resets");
        for (i = 0; i < 9; i = i + 1) begin
            fm[i] = {$random(seed)} % 96;
            wr(8'h01 + i[7:0], {25'h0, fm[i]});
        end
        wr(8'h05, 32'h60);
        wr(8'h23, 32'h5);
        wr(8'h30, 32'h1);
        for (i = 0; i < 9; i = i + 1)
            rc(8'h01 + i[7:0], {25'h0, fm[i]});
        rc(8'h23, 32'h0);
        rc(8'h30, 32'h0);
        $display("done: selects");
        v = {$random(seed)} & 32'h1FF;
        p = {$random(seed)} & 32'h1FF;
        wr(8'h0B, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h0C, 32'h1FF);
        wr(8'h0A, p);
        wr(8'h20, v);
        cyc(10);
        rc(8'h21, v ^ p);
        wr(8'h0C, 32'h0);
        wr(8'h0A, 32'h0);
        wr(8'h20, 32'h1FF);
        setp(5'h15);
        cyc(12);
        rc(8'h21, 32'h105);
        $display("done: sources");
        setp(5'h00);
        wr(8'h01, 32'h1);
        wr(8'h05, 32'h2);
        wr(8'h06, 32'h3);
        wr(8'h0C, 32'h31);
        for (m = 0; m < 4; m = m + 1) begin
            wr(8'h20, 32'h0);
            wr(8'h0D, m);
            cyc(10);
            m_run = 1'b0;
            m_dir = 1'b0;
            p_f = 1'b0;
            p_r = 1'b0;
            rc(8'h0D, m);
            for (k = 0; k < 24; k = k + 1) begin
                v = {$random(seed)} & 32'h7;
                wr(8'h20, {26'h0, v[2], v[1], 3'h0, v[0]});
                cyc(10);
                run_model(m, v[0], v[1], v[2]);
                chk({run_command, reverse_command & run_command}, {m_run, m_dir & m_run});
            end
        end
        $display("done: schemes");
        wr(8'h0C, 32'h0);
        wr(8'h20, 32'h0);
        wr(8'h0D, 32'h0);
        wr(8'h01, 32'h28);
        wr(8'h02, 32'h29);
        wr(8'h03, 32'h2A);
        wr(8'h04, 32'h3D);
        setp(5'h01);
        cyc(10);
        chk(energy_count, 32'h0);
        setp(5'h00);
        cyc(10);
        n = 1 + {$random(seed)} % 20;
        inc(n);
        m_count = m_count + n;
        cyc(4);
        chk(energy_count, m_count);
        setp(5'h02);
        cyc(10);
        inc(n);
        cyc(4);
        chk({energy_hold, energy_count}, {1'b1, m_count});
        setp(5'h0C);
        cyc(10);
        inc(5);
        m_count = m_count + 5;
        cyc(4);
        chk({torque_limit_keypad, pid_invert, energy_count}, {2'b11, m_count});
        setp(5'h0D);
        cyc(10);
        chk(energy_count, 32'h0);
        rc(8'h22, 32'h0C);
        $display("done: functions");
        setp(5'h00);
        wr(8'h0B, 32'h2);
        wr(8'h14, 32'h3);
        cyc(40);
        setp(5'h08);
        cyc(2);
        setp(5'h00);
        cyc(40);
        chk(pid_invert, 1'b0);
        bounce = 4'h5;
        setp(5'h08);
        cyc(10);
        chk(pid_invert, 1'b0);
        cyc(50);
        chk(pid_invert, 1'b1);
        bounce = 4'h0;
        setp(5'h00);
        cyc(40);
        chk(pid_invert, 1'b0);
        $display("done: filter");
        wr(8'h0B, 32'h0);
        wr(8'h00, 32'h0);
        setp(5'h10);
        cyc(10);
        chk(fast_pulse_level, 1'b1);
        rc(8'h21, 32'h0);
        wr(8'h00, 32'h1);
        cyc(10);
        chk(fast_pulse_level, 1'b0);
        rc(8'h21, 32'h100);
        $display("done: fast input type");
        stop_test;
    end
endmodule // ddit_tb_top

bind ddit_top ddit_chk i_ddit_chk (
    .clk(clk), .srst(srst), .addr(addr), .rd_en(rd_en), .rd_data(rd_data),
    .energy_clear(energy_clear), .energy_hold(energy_hold), .energy_count(energy_count),
    .torque_limit_keypad(torque_limit_keypad), .pid_invert(pid_invert),
    .run_command(run_command), .reverse_command(reverse_command), .fast_pulse_level(fast_pulse_level));
